/* hdl/rscl_strap_latch.sv */
// Purpose: Latch strap levels at chip reset release and hold derived config.
// Assumes: Straps, chip reset and bus inputs are synchronous to mclk.
// Notes: The auxiliary clock itself comes from an outside synthesiser.
//
// Contract
// - Straps are inputs during chip reset; level held at release; the code still drives them until the first mclk edge of chip reset.
// - Aux clock strap 0 disables output, driven low; 1 enables it.
// - Software bit controls aux clock enable; strap sets its default.
// - Frequency code 00 25 MHz, 01 50 MHz, 10 125 MHz, 11 reserved.
// - Frequency default bits come from two receive-data straps.
// - Software may rewrite frequency to any non-reserved code after reset.
// - Management strap 0 selects managed mode, address from straps A..E.
// - Managed mode takes no strap configuration beyond the address; the code still takes the MAC type strap.
// - Management strap 1 selects unmanaged mode, A..E set configuration.
// - Unmanaged straps set speed, autoneg, duplex, MAC, crossover, delays; the code fixes crossover at MDIX_AUTO.
// - Unmanaged mode sets power saving enable by default.
// - A,B select both clock delays: 000, 010, 100, 110.
// - C,D select autoneg 10/100, forced 100 half, or forced 10 half.
// - Unmanaged strap E 0 selects RGMII, 1 selects RMII; the code leaves E at 0 to the MAC type strap.
// - Inconsistent strap combinations are applied without checking.
// - Unmanaged address upper bits zero, low two from address straps.
// - MAC type strap 0 selects RGMII, 1 selects MII.
// - Unmanaged with E set uses RMII whatever the MAC type strap.
// - Autoneg cleared makes speed and duplex bits decide operation.
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module rscl_strap_latch
	import rscl_pkg::*;
(
	// Clock and reset.
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic chipResetLow,
	// Shared strap pins.
	input wire logic [PIN_COUNT-1:0] strapPinIn,
	output logic [PIN_COUNT-1:0] strapPinOut,
	output logic [PIN_COUNT-1:0] strapPinOe,
	// Functional pin data and synthesised aux clock.
	input wire logic [PIN_COUNT-1:0] pinFuncData,
	input wire logic auxClockSrc,
	// Avalon-MM slave.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Derived configuration.
	output logic managedMode,
	output logic [4:0] phyAddr,
	output logic auxClkEnable,
	output logic [1:0] auxFreqSel,
	output logic speed100,
	output logic anegEnable,
	output logic fullDuplex,
	output logic [1:0] macIfSel,
	output logic [1:0] mdixForce,
	output logic [2:0] rxClkDelay,
	output logic [2:0] txClkDelay,
	output logic powerSaveEn
);

	// ==========================================================
	// Functions.

	// Both clock delay fields share one code built from straps A and B.
	function automatic logic [2:0] delayCode(input logic sigA, input logic sigB);
		return {sigA, sigB, 1'b0};
	endfunction

	// MAC interface choice; strap E only counts in unmanaged mode.
	// Strap E low leaves the choice to the MAC type strap, so RGMII needs it low too.
	function automatic logic [1:0] macSelect(input logic [PIN_COUNT-1:0] s);
		logic [1:0] mac;
		mac = s[PIN_MACTYPE] ? MAC_MII : MAC_RGMII;
		if (s[PIN_MGMT] && s[PIN_SIGE]) begin
			mac = MAC_RMII;
		end
		return mac;
	endfunction

	// Unmanaged defaults from straps A..E.
	function automatic logic [CFG_W-1:0] cfgUnmanaged(input logic [PIN_COUNT-1:0] s);
		logic [CFG_W-1:0] c;
		c = CFG_RESET;
		// Combinations such as RMII with C,D at 00 pass unchecked.
		c[CFG_RXDLY_LSB +: 3] = delayCode(s[PIN_SIGA], s[PIN_SIGB]);
		c[CFG_TXDLY_LSB +: 3] = delayCode(s[PIN_SIGA], s[PIN_SIGB]);
		c[CFG_ANEG] = ~s[PIN_SIGC];
		c[CFG_SPEED] = ~(s[PIN_SIGC] & s[PIN_SIGD]);
		c[CFG_DUPLEX] = ~s[PIN_SIGC];
		c[CFG_MDIX_LSB +: 2] = MDIX_AUTO;
		c[CFG_MAC_LSB +: 2] = macSelect(s);
		c[CFG_PWRSAVE] = 1'b1;
		return c;
	endfunction

	// Managed defaults ignore straps A..E; only the MAC type strap counts.
	function automatic logic [CFG_W-1:0] cfgManaged(input logic [PIN_COUNT-1:0] s);
		logic [CFG_W-1:0] c;
		c = CFG_RESET;
		c[CFG_RXDLY_LSB +: 3] = DLY_NONE;
		c[CFG_TXDLY_LSB +: 3] = DLY_NONE;
		c[CFG_MDIX_LSB +: 2] = MDIX_AUTO;
		c[CFG_MAC_LSB +: 2] = macSelect(s);
		c[CFG_PWRSAVE] = 1'b0;
		return c;
	endfunction

	// Configuration defaults from the strap levels.
	function automatic logic [CFG_W-1:0] cfgDefault(input logic [PIN_COUNT-1:0] s);
		logic [CFG_W-1:0] c;
		if (s[PIN_MGMT]) begin
			c = cfgUnmanaged(s);
		end else begin
			c = cfgManaged(s);
		end
		return c;
	endfunction

	// PHY address from the straps of the selected mode.
	function automatic logic [4:0] addrDefault(input logic [PIN_COUNT-1:0] s);
		logic [4:0] a;
		if (s[PIN_MGMT]) begin
			a = {3'h0, s[PIN_ADDR1], s[PIN_ADDR0]};
		end else begin
			a = {s[PIN_SIGE], s[PIN_SIGD], s[PIN_SIGC], s[PIN_SIGB], s[PIN_SIGA]};
		end
		return a;
	endfunction

	// Frequency default from the two frequency straps.
	function automatic logic [1:0] freqDefault(input logic [PIN_COUNT-1:0] s);
		return {s[PIN_FREQ1], s[PIN_FREQ0]};
	endfunction

	// Only codes that name a real frequency may be written by software.
	function automatic logic freqAllowed(input logic [1:0] code);
		return code != FREQ_RESERVED;
	endfunction

	// Address decode for one register.
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction

	// Byte-enable merge of a write into an old word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// State.
	logic inReset;
	logic waitReq_reg;
	logic [31:0] readData_reg;
	logic wrFire;
	logic [PIN_COUNT-1:0] strapLatch_reg;
	logic [PIN_COUNT-1:0] pinOut_reg;
	logic [PIN_COUNT-1:0] pinOe_reg;
	logic [4:0] phyAddr_reg;
	logic managed_reg;
	logic [CFG_W-1:0] cfg_reg;
	logic [CFG_W-1:0] cfg_next;
	logic [2:0] aux_reg;
	logic [31:0] auxWord;
	logic [31:0] cfgWord;
	logic [31:0] rdMux;
	logic [31:0] cfgMerged;
	logic [31:0] strapWord;
	logic [31:0] addrWord;

	assign inReset = ~chipResetLow;
	assign wrFire = avs_write & ~waitReq_reg;

	// ==========================================================
	// Strap capture.

	// Sampled every cycle of chip reset, so the held value is the release level.
	// The pin enable lags chip reset by one cycle, so a one-cycle reset latches driven data.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			strapLatch_reg <= '0;
		end else if (inReset) begin
			strapLatch_reg <= strapPinIn;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			managed_reg <= 1'b0;
		end else if (inReset) begin
			managed_reg <= ~strapPinIn[PIN_MGMT];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			phyAddr_reg <= '0;
		end else if (inReset) begin
			phyAddr_reg <= addrDefault(strapPinIn);
		end
	end

	// ==========================================================
	// Pin drive.

	// Pins go undriven one cycle into chip reset, so from then on only the pulls are seen.
	always_ff @(posedge mclk) begin
		if (sys_rst || inReset) begin
			pinOe_reg <= '0;
		end else begin
			pinOe_reg <= '1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || inReset) begin
			pinOut_reg <= '0;
		end else begin
			pinOut_reg <= pinFuncData;
			pinOut_reg[PIN_AUXCLK] <= aux_reg[AUX_EN_BIT] & auxClockSrc;
		end
	end

	// ==========================================================
	// Auxiliary clock control.

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			aux_reg <= AUX_RESET;
		end else if (inReset) begin
			aux_reg[AUX_EN_BIT] <= strapPinIn[PIN_AUXCLK];
			aux_reg[AUX_FREQ_LSB +: 2] <= freqDefault(strapPinIn);
		end else if (wrFire && hit(avs_address, OFS_AUXCTRL) && avs_byteenable[0]) begin
			aux_reg[AUX_EN_BIT] <= avs_writedata[AUX_EN_BIT];
			// The reserved code is refused on writes; a reserved strap default still reaches the synthesiser.
			if (freqAllowed(avs_writedata[AUX_FREQ_LSB +: 2])) begin
				aux_reg[AUX_FREQ_LSB +: 2] <= avs_writedata[AUX_FREQ_LSB +: 2];
			end
		end
	end

	// ==========================================================
	// Configuration word.

	assign cfgMerged = merge(cfgWord, avs_writedata, avs_byteenable);

	always_comb begin
		cfg_next = cfgMerged[CFG_W-1:0];
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cfg_reg <= CFG_RESET;
		end else if (inReset) begin
			cfg_reg <= cfgDefault(strapPinIn);
		end else if (wrFire && hit(avs_address, OFS_CONFIG)) begin
			cfg_reg <= cfg_next;
		end
	end

	// ==========================================================
	// Avalon-MM slave.

	assign auxWord = {29'h0, aux_reg};
	assign cfgWord = {{(32 - CFG_W){1'b0}}, cfg_reg};
	assign strapWord = {{(32 - PIN_COUNT){1'b0}}, strapLatch_reg};
	assign addrWord = {26'h0, managed_reg, phyAddr_reg};

	always_comb begin
		rdMux = 32'h0;
		case (avs_address)
			OFS_AUXCTRL: rdMux = auxWord;
			OFS_STRAPS: rdMux = strapWord;
			OFS_ADDR: rdMux = addrWord;
			OFS_CONFIG: rdMux = cfgWord;
			default: rdMux = 32'h0;
		endcase
	end

	// One wait cycle per access; the answer stands at the edge it is released.
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			waitReq_reg <= 1'b1;
		end else if ((avs_read || avs_write) && waitReq_reg) begin
			waitReq_reg <= 1'b0;
		end else begin
			waitReq_reg <= 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			readData_reg <= 32'h0;
		end else if (avs_read && waitReq_reg) begin
			readData_reg <= rdMux;
		end
	end

	// ==========================================================
	// Outputs.

	assign avs_waitrequest = waitReq_reg;
	assign avs_readdata = readData_reg;
	assign strapPinOut = pinOut_reg;
	assign strapPinOe = pinOe_reg;
	assign managedMode = managed_reg;
	assign phyAddr = phyAddr_reg;
	assign auxClkEnable = aux_reg[AUX_EN_BIT];
	assign auxFreqSel = aux_reg[AUX_FREQ_LSB +: 2];
	assign speed100 = cfg_reg[CFG_SPEED];
	assign anegEnable = cfg_reg[CFG_ANEG];
	assign fullDuplex = cfg_reg[CFG_DUPLEX];
	assign macIfSel = cfg_reg[CFG_MAC_LSB +: 2];
	assign mdixForce = cfg_reg[CFG_MDIX_LSB +: 2];
	assign rxClkDelay = cfg_reg[CFG_RXDLY_LSB +: 3];
	assign txClkDelay = cfg_reg[CFG_TXDLY_LSB +: 3];
	assign powerSaveEn = cfg_reg[CFG_PWRSAVE];

endmodule // rscl_strap_latch

/* hdl/rscl_pkg.sv */
// Purpose: Constants for the reset strap configuration latch.
// Assumes: Registers are 32-bit words at byte offsets on an Avalon-MM slave.
// Notes: Pin indices place each strap in the shared pin vector.
package rscl_pkg;
	// ==========================================================
	// Strap pin indices.
	localparam int PIN_COUNT = 12;
	localparam int PIN_AUXCLK = 0;
	localparam int PIN_MGMT = 1;
	localparam int PIN_SIGA = 2;
	localparam int PIN_SIGB = 3;
	localparam int PIN_SIGC = 4;
	localparam int PIN_SIGD = 5;
	localparam int PIN_SIGE = 6;
	localparam int PIN_MACTYPE = 7;
	localparam int PIN_ADDR0 = 8;
	localparam int PIN_ADDR1 = 9;
	localparam int PIN_FREQ0 = 10;
	localparam int PIN_FREQ1 = 11;
	// ==========================================================
	// Register byte offsets.
	localparam logic [3:0] OFS_AUXCTRL = 4'h0;
	localparam logic [3:0] OFS_STRAPS = 4'h4;
	localparam logic [3:0] OFS_ADDR = 4'h8;
	localparam logic [3:0] OFS_CONFIG = 4'hc;
	// ==========================================================
	// Auxiliary clock control fields.
	localparam int AUX_EN_BIT = 0;
	localparam int AUX_FREQ_LSB = 1;
	localparam logic [1:0] FREQ_25MHZ = 2'h0;
	localparam logic [1:0] FREQ_50MHZ = 2'h1;
	localparam logic [1:0] FREQ_125MHZ = 2'h2;
	localparam logic [1:0] FREQ_RESERVED = 2'h3;
	// ==========================================================
	// Configuration word fields.
	localparam int CFG_W = 14;
	localparam int CFG_SPEED = 0;
	localparam int CFG_ANEG = 1;
	localparam int CFG_DUPLEX = 2;
	localparam int CFG_MAC_LSB = 3;
	localparam int CFG_MDIX_LSB = 5;
	localparam int CFG_RXDLY_LSB = 7;
	localparam int CFG_TXDLY_LSB = 10;
	localparam int CFG_PWRSAVE = 13;
	localparam logic [1:0] MAC_MII = 2'h0;
	localparam logic [1:0] MAC_RMII = 2'h1;
	localparam logic [1:0] MAC_RGMII = 2'h2;
	localparam logic [1:0] MDIX_AUTO = 2'h0;
	localparam logic [2:0] DLY_NONE = 3'h0;
	localparam int MGD_BIT = 5;
	// ==========================================================
	// Reset values.
	localparam logic [CFG_W-1:0] CFG_RESET = 14'h0007;
	localparam logic [2:0] AUX_RESET = 3'h0;
endpackage

/* testbench/rscl_board_model.sv */
// Purpose: Board pull resistors on the shared strap pins.
// Assumes: Nothing else on the board drives these pins.
// Notes: A released pin settles to its pull level, never to a stale value.
`timescale 1ns/1ps
module rscl_board_model
	import rscl_pkg::*;
(
	// Device side.
	input wire logic [PIN_COUNT-1:0] strapPinOut,
	input wire logic [PIN_COUNT-1:0] strapPinOe,
	// Board pulls.
	input wire logic [PIN_COUNT-1:0] pullLevel,
	output logic [PIN_COUNT-1:0] strapPinIn
);
	// ====
	// Wire level.
	assign strapPinIn = (strapPinOe & strapPinOut) | (~strapPinOe & pullLevel);
endmodule // rscl_board_model

/* testbench/rscl_strap_latch_sva.sv */
// Purpose: Checks strap capture and the derived configuration.
// Assumes: Only the ports of rscl_strap_latch are seen.
// Notes: Outputs follow the straps one cycle after each sampling edge.
`timescale 1ns/1ps
module rscl_strap_sva
	import rscl_pkg::*;
(
	// Clock, resets and pins.
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic chipResetLow,
	input wire logic [PIN_COUNT-1:0] strapPinIn,
	input wire logic [PIN_COUNT-1:0] strapPinOut,
	input wire logic [PIN_COUNT-1:0] strapPinOe,
	// Derived configuration.
	input wire logic managedMode,
	input wire logic [4:0] phyAddr,
	input wire logic auxClkEnable,
	input wire logic [1:0] auxFreqSel,
	input wire logic speed100,
	input wire logic anegEnable,
	input wire logic fullDuplex,
	input wire logic [1:0] macIfSel,
	input wire logic [2:0] rxClkDelay,
	input wire logic [2:0] txClkDelay,
	input wire logic powerSaveEn
);
	// ====
	// Properties.
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_take; !chipResetLow; endsequence
	sequence s_unm; s_take ##0 strapPinIn[PIN_MGMT]; endsequence
	property p_oe; s_take |=> strapPinOe == '0; endproperty
	a_oe: assert property (p_oe) else $error("pin driven in chip reset");
	property p_mode; s_take |=> managedMode == !$past(strapPinIn[PIN_MGMT]); endproperty
	a_mode: assert property (p_mode) else $error("mode wrong");
	property p_mgd; s_take ##0 !strapPinIn[PIN_MGMT] |=> phyAddr == $past(strapPinIn[6:2])
		&& macIfSel == ($past(strapPinIn[PIN_MACTYPE]) ? MAC_MII : MAC_RGMII) && !powerSaveEn;
	endproperty
	a_mgd: assert property (p_mgd) else $error("managed setup wrong");
	property p_uaddr; s_unm |=> phyAddr == {3'h0, $past(strapPinIn[9:8])} && powerSaveEn;
	endproperty
	a_uaddr: assert property (p_uaddr) else $error("unmanaged address wrong");
	property p_dly; s_unm |=> txClkDelay == rxClkDelay
		&& rxClkDelay == {$past(strapPinIn[PIN_SIGA]), $past(strapPinIn[PIN_SIGB]), 1'b0};
	endproperty
	a_dly: assert property (p_dly) else $error("delay wrong");
	property p_adv; s_unm |=> anegEnable == !$past(strapPinIn[PIN_SIGC]) && fullDuplex == anegEnable
		&& speed100 == !($past(strapPinIn[PIN_SIGC]) && $past(strapPinIn[PIN_SIGD]));
	endproperty
	a_adv: assert property (p_adv) else $error("advertisement wrong");
	property p_mac; s_unm |=> macIfSel == ($past(strapPinIn[PIN_SIGE]) ? MAC_RMII
		: ($past(strapPinIn[PIN_MACTYPE]) ? MAC_MII : MAC_RGMII));
	endproperty
	a_mac: assert property (p_mac) else $error("interface wrong");
	property p_freq; s_take |=> auxFreqSel == $past(strapPinIn[11:10])
		&& auxClkEnable == $past(strapPinIn[PIN_AUXCLK]);
	endproperty
	a_freq: assert property (p_freq) else $error("aux default wrong");
	property p_auxlow; !auxClkEnable |=> !strapPinOut[PIN_AUXCLK]; endproperty
	a_auxlow: assert property (p_auxlow) else $error("aux pin not low");
	property p_hold; chipResetLow && $past(chipResetLow) && !$past(sys_rst)
		|-> $stable(managedMode) && $stable(phyAddr);
	endproperty
	a_hold: assert property (p_hold) else $error("latched value moved");
endmodule // rscl_strap_sva

bind rscl_strap_latch rscl_strap_sva u_sva (.mclk, .sys_rst, .chipResetLow, .strapPinIn,
	.strapPinOut, .strapPinOe, .managedMode, .phyAddr, .auxClkEnable, .auxFreqSel, .speed100,
	.anegEnable, .fullDuplex, .macIfSel, .rxClkDelay, .txClkDelay, .powerSaveEn);

/* testbench/rscl_strap_latch_tb.sv */
// Purpose: Self-checking bench for rscl_strap_latch.
// Assumes: Straps reach the pins only through board pulls.
// Notes: A hung bus wait is cut short by the cycle ceiling.
`timescale 1ns/1ps
module rscl_strap_latch_tb
	import rscl_pkg::*;
;
	// ====
	// Signals.
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic chipResetLow = 1'b1;
	logic auxClockSrc = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [PIN_COUNT-1:0] pullLevel = 12'h0;
	logic [PIN_COUNT-1:0] pinFuncData = 12'h5a6;
	logic [PIN_COUNT-1:0] strapPinIn, strapPinOut, strapPinOe;
	logic [31:0] avs_readdata, rd, cfg;
	logic avs_waitrequest, managedMode, auxClkEnable, speed100, anegEnable, fullDuplex;
	logic powerSaveEn;
	logic [4:0] phyAddr;
	logic [1:0] auxFreqSel, macIfSel, mdixForce;
	logic [2:0] rxClkDelay, txClkDelay;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cyc = 0;
	assign cfg = 32'({mdixForce, rxClkDelay, txClkDelay, macIfSel, powerSaveEn, anegEnable,
		speed100, fullDuplex});
	rscl_strap_latch dut (.mclk, .sys_rst, .chipResetLow, .strapPinIn, .strapPinOut, .strapPinOe,
		.pinFuncData, .auxClockSrc, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .managedMode, .phyAddr,
		.auxClkEnable, .auxFreqSel, .speed100, .anegEnable, .fullDuplex, .macIfSel, .mdixForce,
		.rxClkDelay, .txClkDelay, .powerSaveEn);
	rscl_board_model board (.strapPinOut, .strapPinOe, .pullLevel, .strapPinIn);
	// ====
	// Clock, ceiling and helpers.
	initial begin
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		auxClockSrc <= ~auxClockSrc;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic strap(input logic [11:0] p);
		pullLevel <= p;
		chipResetLow <= 1'b0;
		repeat (3) @(posedge mclk);
		chipResetLow <= 1'b1;
		repeat (3) @(posedge mclk);
	endtask
	// ====
	// Scenarios.
	task automatic t_managed();
		strap(12'h7ed);
		chk(32'({managedMode, phyAddr, auxClkEnable, auxFreqSel}), 32'h1dd);
		chk(cfg, 32'h7);
		bus(1'b0, OFS_ADDR, 32'h0);
		chk(rd, 32'h3b);
		bus(1'b0, OFS_STRAPS, 32'h0);
		chk(rd, 32'h7ed);
		$display("managed test done");
	endtask
	task automatic t_unmanaged();
		logic [1:0] i;
		logic e;
		logic [31:0] x;
		logic [1:0] m;
		for (int k = 0; k < 4; k++) begin
			i = 2'(k);
			e = !i[0];
			// The first pass straps the interface against the advertisement on purpose.
			strap({1'b0, i[0], i, i[1], e, i[0], i[1], i[0], i[1], 1'b1, i[1]});
			m = e ? MAC_RMII : (i[1] ? MAC_MII : MAC_RGMII);
			x = 32'({MDIX_AUTO, i, 1'b0, i, 1'b0, m, 1'b1, !i[1], !(&i), !i[1]});
			chk(cfg, x);
			x = 32'({4'h0, i, 1'b0, i[0], i[1]});
			chk(32'({managedMode, phyAddr, auxFreqSel, auxClkEnable}), x);
		end
		$display("unmanaged test done");
	endtask
	task automatic t_aux_hold();
		logic [1:0] f;
		logic o;
		strap(12'h800);
		chk(32'({auxClkEnable, auxFreqSel, macIfSel}), 32'({1'b0, FREQ_125MHZ, MAC_RGMII}));
		repeat (3) begin
			@(posedge mclk);
			chk(32'(strapPinOut[PIN_AUXCLK]), 32'h0);
		end
		f = FREQ_125MHZ;
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, OFS_AUXCTRL, 32'({2'(c), 1'b1}));
			if (c != 3) f = 2'(c);
			chk(32'({auxClkEnable, auxFreqSel}), 32'({1'b1, f}));
		end
		o = strapPinOut[PIN_AUXCLK];
		@(posedge mclk);
		chk(32'(o ^ strapPinOut[PIN_AUXCLK]), 32'h1);
		pullLevel <= 12'hfff;
		pinFuncData <= 12'hfff;
		bus(1'b1, OFS_ADDR, 32'h3f);
		bus(1'b0, OFS_STRAPS, 32'h0);
		chk(rd, 32'h800);
		chk(32'({managedMode, phyAddr}), 32'h20);
		bus(1'b0, 4'h1, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, OFS_CONFIG, 32'h0);
		chk(cfg & 32'h7, 32'h0);
		avs_byteenable <= 4'h2;
		bus(1'b1, OFS_CONFIG, 32'h3fff);
		bus(1'b0, OFS_CONFIG, 32'h0);
		chk(rd, 32'h3f00);
		avs_byteenable <= 4'he;
		bus(1'b1, OFS_AUXCTRL, 32'h0);
		avs_byteenable <= 4'hf;
		chk(32'({auxClkEnable, auxFreqSel}), 32'({1'b1, FREQ_125MHZ}));
		$display("aux and hold test done");
	endtask
	// ====
	// Main sequence and verdict.
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		t_managed();
		t_unmanaged();
		t_aux_hold();
		end_sim();
	end
endmodule // rscl_strap_latch_tb
